// ==== rtl/mms_mode_select.sv ====
// top: phase detection, mode choice, interleave and register slave
`timescale 1ns/1ps
// Summary of operation
// - three phases unless phase pins strapped high
// - sink detection current on phases two, three
// - pin above threshold disables that phase
// - detection finishes within three oscillator cycles
// - detection sink removed once detection ends
// - strapped pins float, others drive logic
// - phases independent, outputs may overlap
// - heavy load runs all phases PWM
// - light load keeps only phase one
// - multiphase uses PWM on master clock
// - low hint gives ripple mode, CCM
// - deep sleep gives ripple with diode emulation
// - transient or limit forces full PWM
// - any code change opens transient window
// - per phase rate is clock over count
// - ripple ramp ends the phase one pulse
// - ripple rate follows load in DIODE_EMULATION_OUT
// - disable output low in single phase
// - diode emulation low at zero current
// - window length from internal hundred microsecond timer
module mms_mode_select #(
    parameter int MASK_CYC = mms_pkg::MASK_CYCLES
) (
    input  wire logic        clk_sys,
    input  wire logic        rstn,
    input  wire logic [3:0]  address,
    input  wire logic        read,
    input  wire logic        write,
    input  wire logic [31:0] writedata,
    output logic [31:0]      readdata,
    output logic             waitrequest,
    input  wire logic        light_load_hint,
    input  wire logic        deep_sleep_request,
    input  wire logic [6:0]  voltage_code,
    input  wire logic        currentLimitHit,
    input  wire logic        rippleTrip,
    input  wire logic [7:0]  errAmpLevel,
    input  wire logic        zeroCrossDetect,
    input  wire logic        phase2PinHigh,
    input  wire logic        phase3PinHigh,
    output logic             phase1_drive_out,
    output logic             phase2_drive_out,
    output logic             phase2DriveOeN,
    output logic             phase3_drive_out,
    output logic             phase3DriveOeN,
    output logic             detectSinkOn,
    output logic             multiphase_disable_out,
    output logic             diode_emulation_out
);
    localparam logic [14:0] MASK_LOAD = 15'(MASK_CYC);

    logic        ctrlEnable;
    logic [15:0] freq_set_resistor;
    logic [7:0]  ramp_slope_set;

    logic [15:0] oscCount;
    logic        oscTick;
    logic        sinkOn;
    logic        detectDone;
    logic        strapped2;
    logic        strapped3;
    logic [1:0]  phaseCount;

    logic [6:0]  lastCode;
    logic        lastSleep;
    logic        codePrimed;
    logic        codeEvent;
    logic [14:0] maskCount;
    logic        transient;

    logic        forceFull;
    logic        ripple_pulse_mode;
    logic        dcmMode;
    logic [2:0]  activeMask;
    logic [1:0]  rotation;
    logic [2:0]  startVec;
    logic [2:0]  pulseVec;
    logic        running;
    logic        busAccept;

    // next phase index in rotation, skipping disabled ones
    function automatic logic [1:0] nextPhase(input logic [1:0] cur, input logic [2:0] mask);
        logic [1:0] cand;
        cand = cur;
        for (int i = 0; i < 3; i++) begin
            cand = (cand == 2'h2) ? 2'h0 : cand + 2'h1;
            if (mask[cand]) return cand;
        end
        return 2'h0;
    endfunction

    // ---------------- register slave ----------------
    assign busAccept = (read || write) && !waitrequest;

    // one wait cycle, then a single acknowledged cycle
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) waitrequest <= 1'b1;
        else       waitrequest <= !((read || write) && waitrequest);
    end

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            ctrlEnable        <= mms_pkg::CTRL_EN_RST;
            freq_set_resistor <= mms_pkg::OSC_PERIOD_RST;
            ramp_slope_set    <= mms_pkg::SLOPE_RST;
        end else if (write && busAccept) begin
            case (address)
                mms_pkg::ADDR_CTRL:  ctrlEnable <= writedata[mms_pkg::CTRL_EN_BIT];
                mms_pkg::ADDR_OSC: begin
                    // too short a period would stall the interleave
                    if (writedata[15:0] >= mms_pkg::OSC_PERIOD_MIN)
                        freq_set_resistor <= writedata[15:0];
                end
                mms_pkg::ADDR_SLOPE: ramp_slope_set <= writedata[7:0];
                default: ;
            endcase
        end
    end

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) readdata <= 32'h00000000;
        else if (read && waitrequest) begin
            case (address)
                mms_pkg::ADDR_CTRL:   readdata <= {31'h0, ctrlEnable};
                mms_pkg::ADDR_OSC:    readdata <= {16'h0, freq_set_resistor};
                mms_pkg::ADDR_SLOPE:  readdata <= {24'h0, ramp_slope_set};
                mms_pkg::ADDR_STATUS: readdata <= {24'h0, strapped3, strapped2, transient,
                                                   dcmMode, ripple_pulse_mode, detectDone,
                                                   phaseCount};
                default:              readdata <= 32'h00000000;
            endcase
        end
    end

    // ---------------- internal oscillator ----------------
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            oscCount <= 16'h0000;
            oscTick  <= 1'b0;
        end else if (!ctrlEnable) begin
            oscCount <= 16'h0000;
            oscTick  <= 1'b0;
        end else if (oscCount >= freq_set_resistor - 16'h0001) begin
            oscCount <= 16'h0000;
            oscTick  <= 1'b1;
        end else begin
            oscCount <= oscCount + 16'h0001;
            oscTick  <= 1'b0;
        end
    end

    mms_phase_detect u_detect (
        .clk_sys       (clk_sys),
        .rstn          (rstn),
        .enable        (ctrlEnable),
        .oscTick       (oscTick),
        .phase2PinHigh (phase2PinHigh),
        .phase3PinHigh (phase3PinHigh),
        .sinkOn        (sinkOn),
        .detectDone    (detectDone),
        .strapped2     (strapped2),
        .strapped3     (strapped3),
        .phaseCount    (phaseCount)
    );

    assign running    = ctrlEnable && detectDone;
    assign activeMask = {!strapped3, !strapped2, 1'b1};

    // ---------------- transient window ----------------
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            lastCode   <= 7'h00;
            lastSleep  <= 1'b0;
            codePrimed <= 1'b0;
        end else begin
            lastCode   <= voltage_code;
            lastSleep  <= deep_sleep_request;
            codePrimed <= 1'b1;
        end
    end

    // no false window on the first edge after reset, history is unknown there
    assign codeEvent = codePrimed &&
                       ((voltage_code != lastCode) || (deep_sleep_request != lastSleep));

    // restarts on every change, length of the mask timer
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            maskCount <= 15'h0000;
            transient <= 1'b0;
        end else if (codeEvent) begin
            maskCount <= MASK_LOAD - 15'h0001;
            transient <= 1'b1;
        end else if (maskCount != 15'h0000) begin
            maskCount <= maskCount - 15'h0001;
        end else begin
            transient <= 1'b0;
        end
    end

    // ---------------- mode choice ----------------
    assign forceFull = transient || currentLimitHit;

    // full PWM under heavy load without deep sleep, or on transient or limit; else ripple on phase one
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            ripple_pulse_mode <= 1'b0;
            dcmMode           <= 1'b0;
        end else begin
            ripple_pulse_mode <= !forceFull && (!light_load_hint || deep_sleep_request);
            dcmMode           <= !forceFull && deep_sleep_request;
        end
    end

    // ---------------- interleave ----------------
    // one start per master tick, rotating, so rate is tick over count
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            rotation <= 2'h0;
            startVec <= 3'h0;
        end else begin
            startVec <= 3'h0;
            if (!running) rotation <= 2'h0;
            else if (ripple_pulse_mode) begin
                rotation    <= 2'h0;
                startVec[0] <= rippleTrip && !pulseVec[0];
            end else if (oscTick) begin
                startVec[rotation] <= 1'b1;
                rotation           <= nextPhase(rotation, activeMask);
            end
        end
    end

    genvar g;
    generate
        for (g = 0; g < 3; g++) begin : gPhase
            mms_ramp_pulse u_ramp (
                .clk_sys   (clk_sys),
                .rstn      (rstn),
                .active    (running && activeMask[g] && (g == 0 || !ripple_pulse_mode)),
                .start     (startVec[g]),
                .errLevel  (errAmpLevel),
                .slope     (ramp_slope_set),
                .pulseHigh (pulseVec[g])
            );
        end
    endgenerate

    // ---------------- pin drive ----------------
    // strapped pins float; phase two and three pins float until detection is done
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            phase1_drive_out <= 1'b0;
            phase2_drive_out <= 1'b0;
            phase3_drive_out <= 1'b0;
            phase2DriveOeN   <= 1'b1;
            phase3DriveOeN   <= 1'b1;
            detectSinkOn     <= 1'b0;
        end else begin
            phase1_drive_out <= pulseVec[0];
            phase2_drive_out <= pulseVec[1];
            phase3_drive_out <= pulseVec[2];
            phase2DriveOeN   <= !(detectDone && !strapped2);
            phase3DriveOeN   <= !(detectDone && !strapped3);
            detectSinkOn     <= sinkOn;
        end
    end

    // low in single phase or shutdown
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) multiphase_disable_out <= 1'b0;
        else       multiphase_disable_out <= running && !ripple_pulse_mode;
    end

    // low-side gate blocked from zero crossing until next phase one start
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) diode_emulation_out <= 1'b1;
        else if (!dcmMode || startVec[0]) diode_emulation_out <= 1'b1;
        else if (zeroCrossDetect) diode_emulation_out <= 1'b0;
    end

    // ---------------- checks ----------------
    property p_full_on_limit;
        @(posedge clk_sys) disable iff (!rstn)
        currentLimitHit |=> !ripple_pulse_mode;
    endproperty
    a_full_on_limit: assert property (p_full_on_limit) else $error("ripple during limit");

    property p_heavy_pwm;
        @(posedge clk_sys) disable iff (!rstn)
        light_load_hint && !deep_sleep_request |=> !ripple_pulse_mode;
    endproperty
    a_heavy_pwm: assert property (p_heavy_pwm) else $error("ripple under heavy load");

    property p_light_single;
        @(posedge clk_sys) disable iff (!rstn)
        !light_load_hint && !transient && !currentLimitHit && !codeEvent
            |=> ripple_pulse_mode;
    endproperty
    a_light_single: assert property (p_light_single) else $error("no ripple at light load");

    property p_window_opens;
        @(posedge clk_sys) disable iff (!rstn)
        codeEvent |=> transient && maskCount == MASK_LOAD - 15'h0001;
    endproperty
    a_window_opens: assert property (p_window_opens) else $error("window not restarted");

    property p_disable_single;
        @(posedge clk_sys) disable iff (!rstn)
        ripple_pulse_mode |=> !multiphase_disable_out;
    endproperty
    a_disable_single: assert property (p_disable_single) else $error("disable high single");

    property p_zero_cross;
        @(posedge clk_sys) disable iff (!rstn)
        dcmMode && zeroCrossDetect && !startVec[0] |=> !diode_emulation_out;
    endproperty
    a_zero_cross: assert property (p_zero_cross) else $error("emulation not low");

    property p_strap_float;
        @(posedge clk_sys) disable iff (!rstn)
        detectDone && strapped3 |=> phase3DriveOeN && !phase3_drive_out;
    endproperty
    a_strap_float: assert property (p_strap_float) else $error("strapped pin driven");

    property p_rotation_skip;
        @(posedge clk_sys) disable iff (!rstn)
        running && !ripple_pulse_mode && oscTick |=> activeMask[$past(rotation)] ##0
            startVec != 3'h0;
    endproperty
    a_rotation_skip: assert property (p_rotation_skip) else $error("start missed");

    property p_single_phase1;
        @(posedge clk_sys) disable iff (!rstn)
        ripple_pulse_mode && $past(ripple_pulse_mode) |-> startVec[2:1] == 2'h0;
    endproperty
    a_single_phase1: assert property (p_single_phase1) else $error("phase 2/3 started");

endmodule // mms_mode_select

// ==== rtl/mms_pkg.sv ====
// shared constants, state type and decode helper for the phase/mode block
package mms_pkg;

    localparam int CLK_MHZ            = 200;
    localparam int MASK_TIME_US       = 100;
    localparam int MASK_CYCLES        = MASK_TIME_US * CLK_MHZ;
    localparam int DETECT_OSC_CYCLES  = 3;

    localparam logic [3:0] ADDR_CTRL   = 4'h0;
    localparam logic [3:0] ADDR_OSC    = 4'h4;
    localparam logic [3:0] ADDR_SLOPE  = 4'h8;
    localparam logic [3:0] ADDR_STATUS = 4'hC;

    localparam int CTRL_EN_BIT    = 0;
    localparam int ST_COUNT_LSB   = 0;
    localparam int ST_DONE_BIT    = 2;
    localparam int ST_RIPPLE_BIT  = 3;
    localparam int ST_DCM_BIT     = 4;
    localparam int ST_TRANS_BIT   = 5;
    localparam int ST_STRAP2_BIT  = 6;
    localparam int ST_STRAP3_BIT  = 7;

    localparam logic        CTRL_EN_RST    = 1'b0;
    localparam logic [15:0] OSC_PERIOD_RST = 16'h014D;
    localparam logic [7:0]  SLOPE_RST      = 8'h04;
    localparam logic [15:0] OSC_PERIOD_MIN = 16'h0002;

    typedef enum {MMS_IDLE, MMS_DETECT, MMS_RUN} mms_det_e;

    // active phase count from the two strap results
    function automatic logic [1:0] mms_phase_count(input logic s2, input logic s3);
        mms_phase_count = 2'h3 - {1'b0, s2} - {1'b0, s3};
    endfunction

endpackage

// ==== rtl/mms_phase_detect.sv ====
// strap detection of phase count after enable
`timescale 1ns/1ps
module mms_phase_detect (
    input  wire logic       clk_sys,
    input  wire logic       rstn,
    input  wire logic       enable,
    input  wire logic       oscTick,
    input  wire logic       phase2PinHigh,
    input  wire logic       phase3PinHigh,
    output logic            sinkOn,
    output logic            detectDone,
    output logic            strapped2,
    output logic            strapped3,
    output logic [1:0]      phaseCount
);
    mms_pkg::mms_det_e state;
    logic [1:0]        tickCount;

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            state     <= mms_pkg::MMS_IDLE;
            tickCount <= 2'h0;
        end else begin
            case (state)
                mms_pkg::MMS_IDLE: begin
                    tickCount <= 2'h0;
                    if (enable) state <= mms_pkg::MMS_DETECT;
                end
                mms_pkg::MMS_DETECT: begin
                    if (!enable) state <= mms_pkg::MMS_IDLE;
                    else if (oscTick) begin
                        tickCount <= tickCount + 2'h1;
                        // decided on the third oscillator edge
                        if (tickCount == 2'(mms_pkg::DETECT_OSC_CYCLES - 1))
                            state <= mms_pkg::MMS_RUN;
                    end
                end
                mms_pkg::MMS_RUN: begin
                    if (!enable) state <= mms_pkg::MMS_IDLE;
                end
                default: state <= mms_pkg::MMS_IDLE;
            endcase
        end
    end

    // sink only while detecting, so unstrapped pins read low
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) sinkOn <= 1'b0;
        else       sinkOn <= (state == mms_pkg::MMS_DETECT) && enable;
    end

    // latched once, held until the next enable
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            strapped2  <= 1'b0;
            strapped3  <= 1'b0;
            phaseCount <= 2'h3;
            detectDone <= 1'b0;
        end else if (state == mms_pkg::MMS_DETECT && oscTick
                     && tickCount == 2'(mms_pkg::DETECT_OSC_CYCLES - 1)) begin
            strapped2  <= phase2PinHigh;
            strapped3  <= phase3PinHigh;
            phaseCount <= mms_pkg::mms_phase_count(phase2PinHigh, phase3PinHigh);
            detectDone <= 1'b1;
        end else if (state == mms_pkg::MMS_IDLE) begin
            detectDone <= 1'b0;
        end
    end

    property p_sink_ends;
        @(posedge clk_sys) disable iff (!rstn)
        $rose(detectDone) |=> !sinkOn;
    endproperty
    a_sink_ends: assert property (p_sink_ends) else $error("sink still on after detect");

    property p_count_held;
        @(posedge clk_sys) disable iff (!rstn)
        detectDone && $past(detectDone) |-> $stable(phaseCount);
    endproperty
    a_count_held: assert property (p_count_held) else $error("phase count changed");

endmodule // mms_phase_detect

// ==== rtl/mms_ramp_pulse.sv ====
// one phase: set on a start event, ramp until the error level is met
`timescale 1ns/1ps
module mms_ramp_pulse (
    input  wire logic       clk_sys,
    input  wire logic       rstn,
    input  wire logic       active,
    input  wire logic       start,
    input  wire logic [7:0] errLevel,
    input  wire logic [7:0] slope,
    output logic            pulseHigh
);
    logic [8:0] ramp;
    logic [8:0] next_ramp;

    always_comb begin
        next_ramp = ramp + {1'b0, slope};
    end

    // each phase ends on its own ramp, so pulses may overlap
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            pulseHigh <= 1'b0;
            ramp      <= 9'h000;
        end else if (!active) begin
            pulseHigh <= 1'b0;
            ramp      <= 9'h000;
        end else if (start) begin
            pulseHigh <= 1'b1;
            ramp      <= 9'h000;
        end else if (pulseHigh) begin
            ramp <= next_ramp;
            if (next_ramp >= {1'b0, errLevel}) pulseHigh <= 1'b0;
        end
    end

endmodule // mms_ramp_pulse

// ==== sim/mms_gate_model.sv ====
// gate driver and board stand-in: straps, pin levels, pulse counts
`timescale 1ns/1ps
module mms_gate_model (
    input  wire logic            clk_sys,
    input  wire logic            clear,
    input  wire logic [3:2]      strap,
    input  wire logic [3:1]      drive,
    input  wire logic [3:1]      oeN,
    output logic                 phase2PinHigh,
    output logic                 phase3PinHigh,
    output logic                 clash,
    output logic [3:1][7:0]      edges
);
    logic [3:1] last;
    // strap wins; the sink holds a floating pin low
    assign phase2PinHigh = strap[2] | (!oeN[2] & drive[2]);
    assign phase3PinHigh = strap[3] | (!oeN[3] & drive[3]);
    // a driven pin tied to supply would short the rail
    assign clash = |(strap & ~oeN[3:2]);
    always_ff @(posedge clk_sys) begin
        last <= drive;
        for (int k = 1; k <= 3; k++) begin
            if (clear)
                edges[k] <= 8'h00;
            else if (drive[k] & !last[k] & !oeN[k])
                edges[k] <= edges[k] + 8'h01;
        end
    end
endmodule // mms_gate_model

// ==== sim/multiphase_mode_select_tb_top.sv ====
// self-checking bench: straps, phase rate, modes, transient window, registers
`timescale 1ns/1ps
module multiphase_mode_select_tb_top;
    localparam int MASK = 50;
    logic clk_sys = 1'b0, rstn = 1'b0, read = 1'b0, write = 1'b0, clear = 1'b0;
    logic hint = 1'b1, dsr = 1'b0, limitHit = 1'b0, trip = 1'b0, zeroX = 1'b0;
    logic overlap = 1'b0;
    logic [3:0]  address   = 4'h0;
    logic [31:0] writedata = 32'h0;
    logic [6:0]  vcode     = 7'h20;
    logic [7:0]  errAmp    = 8'h30;
    logic [3:2]  strap     = 2'h0;
    logic [31:0] seed      = 32'h00003C97;
    logic [31:0] readdata, rd;
    logic waitrequest, p1, p2, p3, oe2N, oe3N, sink, disOut, diode, pin2, pin3, clash;
    logic [3:1][7:0] edges;
    int tests_run = 0, miscompares = 0;

    always #2.5 clk_sys = ~clk_sys;
    always @(posedge clk_sys) if (p1 & p2) overlap <= 1'b1;

    mms_mode_select #(.MASK_CYC(MASK)) u_dut (.clk_sys(clk_sys), .rstn(rstn),
        .address(address), .read(read), .write(write), .writedata(writedata),
        .readdata(readdata), .waitrequest(waitrequest), .light_load_hint(hint),
        .deep_sleep_request(dsr), .voltage_code(vcode), .currentLimitHit(limitHit),
        .rippleTrip(trip), .errAmpLevel(errAmp), .zeroCrossDetect(zeroX),
        .phase2PinHigh(pin2), .phase3PinHigh(pin3), .phase1_drive_out(p1),
        .phase2_drive_out(p2), .phase2DriveOeN(oe2N), .phase3_drive_out(p3),
        .phase3DriveOeN(oe3N), .detectSinkOn(sink), .multiphase_disable_out(disOut),
        .diode_emulation_out(diode));
    mms_gate_model u_gate (.clk_sys(clk_sys), .clear(clear), .strap(strap),
        .drive({p3, p2, p1}), .oeN({oe3N, oe2N, 1'b0}), .phase2PinHigh(pin2),
        .phase3PinHigh(pin3), .clash(clash), .edges(edges));

    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction

    task automatic give_verdict();
        $display("compares %0d mismatches %0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            miscompares++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge clk_sys);
    endtask

    // entered just after an edge; one idle edge after release
    task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
        int n;
        read <= !wr;
        write <= wr;
        address <= a;
        writedata <= d;
        for (n = 0; n < 50; n++) begin
            @(posedge clk_sys);
            if (waitrequest === 1'b0) break;
        end
        rd = readdata;
        read <= 1'b0;
        write <= 1'b0;
        if (n == 50) begin
            miscompares++;
            give_verdict();
        end
        @(posedge clk_sys);
    endtask

    initial begin
        int n;
        logic [1:0] cnt;
        cyc(5);
        chk({waitrequest, p1, p2, p3, oe2N, oe3N, sink, disOut, diode}, 32'h119);
        chk(readdata, 32'h0);
        cyc(5);
        rstn <= 1'b1;
        cyc(1);
        bus(1'b0, 4'h4, 32'h0);
        chk(rd, 32'h014D);
        bus(1'b0, 4'h8, 32'h0);
        chk(rd, 32'h0004);
        bus(1'b1, 4'h2, 32'hFFFF_FFFF);
        bus(1'b0, 4'h2, 32'h0);
        chk(rd, 32'h0);
        bus(1'b1, 4'h4, 32'h1);
        bus(1'b0, 4'h4, 32'h0);
        chk(rd, 32'h014D);
        bus(1'b1, 4'h4, 32'h28);
        for (int i = 3; i >= 0; i--) begin
            bus(1'b1, 4'h0, 32'h0);
            strap <= i[1:0];
            errAmp <= 8'h10 + {2'h0, rnd() % 64};
            bus(1'b1, 4'h0, 32'h1);
            cyc(3);
            chk(sink, 1'b1);
            for (n = 0; n < 200 && sink === 1'b1; n++) cyc(1);
            chk(n > 80 && n <= 120, 1);
            bus(1'b0, 4'hC, 32'h0);
            cnt = 2'h3 - {1'b0, strap[2]} - {1'b0, strap[3]};
            chk(rd[7:0] & 8'hC7, {strap[3], strap[2], 3'h0, 1'b1, cnt});
            chk({oe3N, oe2N, clash}, {strap, 1'b0});
            strap <= 2'h0;
            cyc(2);
            bus(1'b0, 4'hC, 32'h0);
            chk(rd[1:0], cnt);
            clear <= 1'b1;
            cyc(1);
            clear <= 1'b0;
            cyc(240 * cnt);
            // start point inside the first period is unknown, so allow one either way
            for (int k = 1; k <= 3; k++)
                chk((k == 1 || !i[k-2]) ? (edges[k] >= 5 && edges[k] <= 7)
                                        : edges[k] == 0, 1);
        end
        hint <= 1'b0;
        cyc(5);
        bus(1'b0, 4'hC, 32'h0);
        chk({rd[5:3], disOut}, 4'h2);
        clear <= 1'b1;
        cyc(1);
        clear <= 1'b0;
        repeat (4) begin
            trip <= 1'b1;
            cyc(1);
            trip <= 1'b0;
            cyc(40);
        end
        chk(edges, {8'h00, 8'h00, 8'h04});
        dsr <= 1'b1;
        cyc(3);
        bus(1'b0, 4'hC, 32'h0);
        chk({rd[5], disOut}, 2'h3);
        cyc(MASK + 10);
        bus(1'b0, 4'hC, 32'h0);
        chk({rd[5:3], disOut}, 4'h6);
        zeroX <= 1'b1;
        cyc(1);
        zeroX <= 1'b0;
        cyc(2);
        chk(diode, 1'b0);
        trip <= 1'b1;
        cyc(1);
        trip <= 1'b0;
        cyc(5);
        chk(diode, 1'b1);
        limitHit <= 1'b1;
        cyc(3);
        bus(1'b0, 4'hC, 32'h0);
        chk({rd[4:3], disOut}, 3'h1);
        limitHit <= 1'b0;
        dsr <= 1'b0;
        cyc(MASK + 10);
        repeat (3) begin
            vcode <= vcode ^ (rnd() | 32'h1);
            cyc(3);
            bus(1'b0, 4'hC, 32'h0);
            chk({rd[5], disOut}, 2'h3);
            cyc(MASK - 15);
            bus(1'b0, 4'hC, 32'h0);
            chk(rd[5], 1'b1);
            cyc(20);
            bus(1'b0, 4'hC, 32'h0);
            chk({rd[5:3], disOut}, 4'h2);
        end
        hint <= 1'b1;
        errAmp <= 8'hC8;
        cyc(300);
        chk(overlap, 1'b1);
        bus(1'b0, 4'h0, 32'h0);
        chk(rd, 32'h1);
        bus(1'b1, 4'h8, 32'h8);
        bus(1'b0, 4'h8, 32'h0);
        chk(rd, 32'h8);
        give_verdict();
    end
endmodule // multiphase_mode_select_tb_top
